// >>> hdl/scc_clock_ctrl.sv
// device end: system clock source, pll and power state control
// How it works
// - three references: internal, crystal, external clock
// - reset: sleep, clock stopped, internal reference
// - pll feeds every internal engine clock
// - clock enabled only after wake-up command
// - host selects external source before wake-up
// - default multiplier gives 60MHz from 12MHz
// - frequency select offers 72/60/48/36/24MHz
// - host sends frequency select only while asleep
// - software updates frequency register after wake
// - trim register lowers internal oscillator frequency
// - software never trims oscillator above 12MHz
// - source switch resets system unless already selected
// - frequency byte: code 0/2..6, checked top bits
// - sleep stops clock, pll and oscillator
// - wake-up is three zero bytes, sent twice
`timescale 1ns/1ps
module scc_clock_ctrl
  import scc_pkg::*;
#(
  parameter int SETTLE_CYC = PLL_SETTLE_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  scc_link_if.dev link, // serial command link
  output logic sys_clk_en, // gated clock to all engines running
  output logic pll_on, // pll powered
  output logic osc_on, // reference oscillator powered
  output logic ref_ext, // 1: external crystal/clock, 0: internal
  output logic [2:0] pll_mult, // pll multiple of the reference
  output logic sys_rst, // system reset pulse after source switch
  output logic [31:0] freq_reg, // system frequency register
  output logic [7:0] trim_reg // oscillator trim, higher is slower
);
  logic [2:0] sclk_s, cs_s, mosi_s;
  logic sclk_f, cs_f, sclk_p, cs_p;
  logic [2:0] bit_cnt, next_bit_cnt, byte_cnt, next_byte_cnt;
  logic [7:0] shift, next_shift, b0, b1, b2, next_b0, next_b1, next_b2;
  logic [31:0] next_freq;
  logic [7:0] next_trim, rx_byte;
  logic [21:0] wr_addr;
  logic sclk_rise, frame_end, byte_done;
  scc_power_t state, next_state;
  logic [15:0] settle, next_settle;
  logic [7:0] rst_cnt, next_rst_cnt;
  logic next_ext;
  logic [2:0] next_mult;
  logic pll_stopped, freq_ok;

  // link pins cross domains; a sclk or cs_n level counts once stages 2 and 3 agree, mosi is taken from stage 3
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 3'h0;
      sclk_f <= 1'b0;
      cs_f <= 1'b1;
      sclk_p <= 1'b0;
      cs_p <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      cs_s <= {cs_s[1:0], link.cs_n};
      mosi_s <= {mosi_s[1:0], link.mosi};
      if (sclk_s[1] == sclk_s[2]) begin
        sclk_f <= sclk_s[2];
      end
      if (cs_s[1] == cs_s[2]) begin
        cs_f <= cs_s[2];
      end
      sclk_p <= sclk_f;
      cs_p <= cs_f;
    end
  end

  assign sclk_rise = sclk_f && !sclk_p && !cs_f;
  assign byte_done = sclk_rise && (bit_cnt == 3'h7);
  assign rx_byte = {shift[6:0], mosi_s[2]};
  assign frame_end = cs_f && !cs_p && (byte_cnt >= 3'h3);
  assign wr_addr = {b0[5:0], b1, b2};

  // byte framing and register writes
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_shift = shift;
    next_b0 = b0;
    next_b1 = b1;
    next_b2 = b2;
    next_freq = freq_reg;
    next_trim = trim_reg;
    if (cs_f) begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 3'h0;
    end else if (sclk_rise) begin
      next_shift = rx_byte;
      next_bit_cnt = bit_cnt + 3'h1;
    end
    if (byte_done) begin
      if (byte_cnt != 3'h7) begin
        next_byte_cnt = byte_cnt + 3'h1;
      end
      case (byte_cnt)
        3'h0: next_b0 = rx_byte;
        3'h1: next_b1 = rx_byte;
        3'h2: next_b2 = rx_byte;
        default: begin
          // register writes only land in their own byte lanes
          if (b0[7:6] == HDR_WRITE && wr_addr == ADDR_FREQ) begin
            case (byte_cnt)
              3'h3: next_freq[7:0] = rx_byte;
              3'h4: next_freq[15:8] = rx_byte;
              3'h5: next_freq[23:16] = rx_byte;
              3'h6: next_freq[31:24] = rx_byte;
              default: next_freq = freq_reg;
            endcase
          end
          if (b0[7:6] == HDR_WRITE && wr_addr == ADDR_TRIM &&
              byte_cnt == 3'h3) begin
            next_trim = rx_byte;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shift <= 8'h00;
      b0 <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      freq_reg <= FREQ_RESET;
      trim_reg <= TRIM_RESET;
    end else begin
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      shift <= next_shift;
      b0 <= next_b0;
      b1 <= next_b1;
      b2 <= next_b2;
      freq_reg <= next_freq;
      trim_reg <= next_trim;
    end
  end

  assign pll_stopped = (state == PWR_SLEEP) || (state == PWR_DOWN);
  // selector 1 is reserved; top bits must match the range of the code
  always_comb begin
    case (b1[5:0])
      6'h00, 6'h02, 6'h03: freq_ok = (b1[7:6] == 2'h0);
      6'h04, 6'h05, 6'h06: freq_ok = (b1[7:6] == 2'h1);
      default: freq_ok = 1'b0;
    endcase
  end

  // power, source and frequency commands act at the end of a frame
  always_comb begin
    next_state = state;
    next_settle = settle;
    next_rst_cnt = rst_cnt;
    next_ext = ref_ext;
    next_mult = pll_mult;
    if (settle != 16'h0000) begin
      next_settle = settle - 16'h0001;
    end
    if (rst_cnt != 8'h00) begin
      next_rst_cnt = rst_cnt - 8'h01;
    end
    if (frame_end && b2 == 8'h00) begin
      case (b0)
        CMD_ACTIVE: begin
          // three zero bytes; a repeated wake-up is harmless
          if (b1 == 8'h00 && pll_stopped) begin
            next_state = PWR_ACTIVE;
            next_settle = SETTLE_CYC[15:0];
          end else if (b1 == 8'h00 && state == PWR_STANDBY) begin
            next_state = PWR_ACTIVE;
          end
        end
        CMD_STANDBY: begin
          if (state == PWR_ACTIVE) begin
            next_state = PWR_STANDBY;
          end
        end
        CMD_SLEEP: begin
          next_state = PWR_SLEEP;
          next_settle = 16'h0000;
        end
        CMD_PWRDOWN_A, CMD_PWRDOWN_B: begin
          next_state = PWR_DOWN;
          next_settle = 16'h0000;
          next_mult = MULT_DEFAULT;
        end
        CMD_SEL_EXT: begin
          if (!ref_ext) begin
            next_ext = 1'b1;
            next_rst_cnt = SYS_RST_CYC[7:0];
          end
        end
        CMD_SEL_INT: begin
          if (ref_ext) begin
            next_ext = 1'b0;
            next_rst_cnt = SYS_RST_CYC[7:0];
          end
        end
        CMD_FREQ_A, CMD_FREQ_B: begin
          // a running pll keeps its multiple
          if (pll_stopped && freq_ok) begin
            next_mult = (b1[5:0] == 6'h00) ? MULT_DEFAULT : b1[2:0];
          end
        end
        CMD_RST_PULSE: next_rst_cnt = SYS_RST_CYC[7:0];
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PWR_SLEEP;
      settle <= 16'h0000;
      rst_cnt <= 8'h00;
      ref_ext <= 1'b0;
      pll_mult <= MULT_DEFAULT;
      sys_clk_en <= 1'b0;
      pll_on <= 1'b0;
      osc_on <= 1'b0;
      sys_rst <= 1'b0;
    end else begin
      state <= next_state;
      settle <= next_settle;
      rst_cnt <= next_rst_cnt;
      ref_ext <= next_ext;
      pll_mult <= next_mult;
      // one gate for every engine clock, opened only once locked
      sys_clk_en <= (next_state == PWR_ACTIVE) &&
                    (next_settle == 16'h0000);
      pll_on <= (next_state == PWR_ACTIVE) ||
                (next_state == PWR_STANDBY);
      osc_on <= (next_state == PWR_ACTIVE) ||
                (next_state == PWR_STANDBY);
      sys_rst <= (next_rst_cnt != 8'h00);
    end
  end
endmodule

// >>> hdl/scc_host_ctrl.sv
// host end: apb-driven serial command sender
`timescale 1ns/1ps
module scc_host_ctrl
  import scc_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  scc_link_if.host link // serial command link
);
  typedef enum {H_IDLE, H_LEAD, H_HIGH, H_LOW, H_TRAIL, H_GAP} scc_hstate_t;
  scc_hstate_t hs, next_hs;
  logic [31:0] data_reg, next_data, next_prdata;
  logic [55:0] tx_sr, next_tx;
  logic [5:0] bits_left, next_bits;
  logic [7:0] tmr, next_tmr;
  logic sclk_q, cs_q, mosi_q, next_sclk, next_cs, next_mosi;
  logic next_pready, next_pslverr, wr_go, mapped;
  logic [2:0] len;

  assign mapped = (paddr == REG_CTRL) || (paddr == REG_DATA) ||
                  (paddr == REG_STATUS);
  assign wr_go = psel && penable && pready && pwrite && !pslverr;
  assign len = (pwdata[CTRL_LEN_LSB +: 3] > 3'h4) ? 3'h4 :
               pwdata[CTRL_LEN_LSB +: 3];

  always_comb begin
    next_hs = hs;
    next_data = data_reg;
    next_tx = tx_sr;
    next_bits = bits_left;
    next_tmr = (tmr != 8'h00) ? tmr - 8'h01 : 8'h00;
    next_sclk = sclk_q;
    next_cs = cs_q;
    next_mosi = mosi_q;
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    next_prdata = 32'h0000_0000;
    if (psel && !penable && paddr == REG_STATUS) begin
      next_prdata[STATUS_BUSY_BIT] = (hs != H_IDLE);
    end else if (psel && !penable && paddr == REG_DATA) begin
      next_prdata = data_reg;
    end
    if (wr_go && paddr == REG_DATA) begin
      next_data = pwdata;
    end
    case (hs)
      H_IDLE: begin
        // a start while busy is dropped; poll the busy bit first
        if (wr_go && paddr == REG_CTRL) begin
          next_tx = {pwdata[7:0], pwdata[15:8], pwdata[23:16],
                     data_reg[7:0], data_reg[15:8], data_reg[23:16],
                     data_reg[31:24]};
          next_bits = 6'(8 * (3 + int'(len)));
          next_cs = 1'b0;
          next_mosi = pwdata[7];
          next_tmr = HALF_CYC[7:0];
          next_hs = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (tmr == 8'h00) begin
          next_sclk = 1'b1;
          next_tmr = HALF_CYC[7:0];
          next_hs = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tmr == 8'h00) begin
          next_sclk = 1'b0;
          next_tx = {tx_sr[54:0], 1'b0};
          next_mosi = tx_sr[54];
          next_bits = bits_left - 6'h01;
          next_tmr = HALF_CYC[7:0];
          next_hs = (bits_left == 6'h01) ? H_TRAIL : H_LOW;
        end
      end
      H_TRAIL: begin
        if (tmr == 8'h00) begin
          next_cs = 1'b1;
          next_mosi = 1'b0;
          next_tmr = GAP_CYC[7:0];
          next_hs = H_GAP;
        end
      end
      H_GAP: begin
        // the gap lets the far end see chip select high between frames
        if (tmr == 8'h00) begin
          next_hs = H_IDLE;
        end
      end
      default: next_hs = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs <= H_IDLE;
      data_reg <= 32'h0000_0000;
      tx_sr <= 56'h00_0000_0000_0000;
      bits_left <= 6'h00;
      tmr <= 8'h00;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      mosi_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      hs <= next_hs;
      data_reg <= next_data;
      tx_sr <= next_tx;
      bits_left <= next_bits;
      tmr <= next_tmr;
      sclk_q <= next_sclk;
      cs_q <= next_cs;
      mosi_q <= next_mosi;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign link.mosi = mosi_q;
endmodule

// >>> shared/scc_link_if.sv
// serial command link between host and clock control
`timescale 1ns/1ps
interface scc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  modport host (output sclk, output cs_n, output mosi);
  modport dev (input sclk, input cs_n, input mosi);
endinterface

// >>> shared/scc_pkg.sv
// shared constants for the system clock control link
package scc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_SETTLE_NS = 1000;
  localparam int PLL_SETTLE_CYC =
    (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYS_RST_NS = 200;
  localparam int SYS_RST_CYC =
    (SYS_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 6;
  localparam int GAP_CYC = 12;
  // first byte of each host command
  localparam logic [7:0] CMD_ACTIVE = 8'h00;
  localparam logic [7:0] CMD_STANDBY = 8'h41;
  localparam logic [7:0] CMD_SLEEP = 8'h42;
  localparam logic [7:0] CMD_PWRDOWN_A = 8'h43;
  localparam logic [7:0] CMD_PWRDOWN_B = 8'h50;
  localparam logic [7:0] CMD_SEL_EXT = 8'h44;
  localparam logic [7:0] CMD_SEL_INT = 8'h48;
  localparam logic [7:0] CMD_FREQ_A = 8'h61;
  localparam logic [7:0] CMD_FREQ_B = 8'h62;
  localparam logic [7:0] CMD_RST_PULSE = 8'h68;
  localparam logic [1:0] HDR_CMD = 2'h1;
  localparam logic [1:0] HDR_WRITE = 2'h2;
  // device memory-mapped registers
  localparam logic [21:0] ADDR_FREQ = 22'h00_1000;
  localparam logic [21:0] ADDR_TRIM = 22'h00_1004;
  localparam logic [31:0] FREQ_RESET = 32'h0393_8700;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [2:0] MULT_DEFAULT = 3'h5;
  // host apb registers
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_DATA = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam int CTRL_LEN_LSB = 24;
  localparam int STATUS_BUSY_BIT = 0;
  typedef enum {PWR_SLEEP, PWR_STANDBY, PWR_ACTIVE, PWR_DOWN} scc_power_t;
endpackage

// >>> tb/scc_link_monitor.sv
// link and clock-output checker for the clock control pair
`timescale 1ns/1ps
module scc_link_monitor
  import scc_pkg::*;
#(
  parameter int SETTLE = 100
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic sclk, // link clock
  input wire logic cs_n, // frame select, active low
  input wire logic mosi, // link data
  input wire logic sys_clk_en, // engine clock running
  input wire logic pll_on, // pll powered
  input wire logic osc_on, // oscillator powered
  input wire logic ref_ext, // external reference chosen
  input wire logic [2:0] pll_mult, // pll multiple
  input wire logic sys_rst // system reset pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // cycles with the pll powered, saturating so standby wakes pass
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (!pll_on)
      next_cnt = 10'h000;
    else if (cnt != 10'h3ff)
      next_cnt = cnt + 10'h001;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      cnt <= 10'h000;
    else
      cnt <= next_cnt;
  end
  // twenty cycles high, split so each repetition stays small
  sequence rst_hold;
    sys_rst [*8] ##1 sys_rst [*8] ##1 sys_rst [*4];
  endsequence
  a_reset_sleep: assert property ($rose(rst_n) |->
    !pll_on && !sys_clk_en && !ref_ext && pll_mult == MULT_DEFAULT)
    else $error("bad state after reset");
  a_rst_pulse_len: assert property ($rose(sys_rst) |->
    rst_hold ##1 !sys_rst) else $error("system reset pulse length wrong");
  a_src_switch_rst: assert property ($changed(ref_ext) |->
    ##[0:2] sys_rst) else $error("source switch without system reset");
  a_clk_needs_pll: assert property (sys_clk_en |-> pll_on && osc_on)
    else $error("engine clock with pll or oscillator off");
  a_settle_gate: assert property ($rose(sys_clk_en) |->
    cnt >= SETTLE - 2) else $error("engine clock before pll settled");
  a_wake_after_frame: assert property ($rose(sys_clk_en) |-> cs_n)
    else $error("engine clock started inside a frame");
  a_mult_frozen: assert property (pll_on && $past(pll_on) |->
    $stable(pll_mult)) else $error("pll multiple changed while running");
  a_sclk_idle_low: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock moving outside a frame");
  a_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("link data moved at the sampling edge");
endmodule

// >>> tb/system_clock_control_test.sv
// self-checking bench for the host and device clock control pair
`timescale 1ns/1ps
module system_clock_control_test
  import scc_pkg::*;
;
  localparam int ST = 40;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, freq_reg, r;
  logic pready, pslverr, sys_clk_en, pll_on, osc_on, ref_ext, sys_rst, e;
  logic [2:0] pll_mult;
  logic [7:0] trim_reg, op;
  logic rst_seen = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int m_awake = 0, m_ext = 0, m_mult = 5, m_rst = 0;
  logic [31:0] m_freq = FREQ_RESET;
  logic [7:0] m_trim = TRIM_RESET;
  logic [7:0] fs [8] = '{8'h02, 8'h03, 8'h44, 8'h45, 8'h46, 8'h04, 8'h42,
    8'h00};
  scc_link_if scc_link_if_i ();
  scc_host_ctrl #(.HALF_CYC(6)) scc_host_ctrl_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(scc_link_if_i.host));
  scc_clock_ctrl #(.SETTLE_CYC(ST)) scc_clock_ctrl_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(scc_link_if_i.dev), .sys_clk_en(sys_clk_en),
    .pll_on(pll_on), .osc_on(osc_on), .ref_ext(ref_ext),
    .pll_mult(pll_mult), .sys_rst(sys_rst), .freq_reg(freq_reg),
    .trim_reg(trim_reg));
  scc_link_monitor #(.SETTLE(ST)) scc_link_monitor_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .sclk(scc_link_if_i.sclk), .cs_n(scc_link_if_i.cs_n),
    .mosi(scc_link_if_i.mosi), .sys_clk_en(sys_clk_en), .pll_on(pll_on),
    .osc_on(osc_on), .ref_ext(ref_ext), .pll_mult(pll_mult),
    .sys_rst(sys_rst));
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sys_rst === 1'b1) rst_seen = 1'b1;
  task stop_test;
    $display("counts: %0d checks, %0d mismatches", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ok;
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      // answer is registered: its level mid-cycle is what the edge takes
      @(negedge ref_clk);
      ok = (pready === 1'b1);
      r = prdata;
      e = pslverr;
      @(posedge ref_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task model(input logic [7:0] b0, b1, b2, input logic [31:0] d);
    logic [5:0] v;
    v = b1[5:0];
    m_rst = 0;
    if (b0 == 8'h80 && b1 == 8'h10) begin
      if (b2 == 8'h00) m_freq = d;
      if (b2 == 8'h04) m_trim = d[7:0];
    end else if (b2 == 8'h00) begin
      case (b0)
        CMD_ACTIVE: m_awake = 1;
        CMD_SLEEP: m_awake = 0;
        CMD_SEL_EXT: begin
          m_rst = !m_ext;
          m_ext = 1;
        end
        CMD_SEL_INT: begin
          m_rst = m_ext;
          m_ext = 0;
        end
        CMD_FREQ_A, CMD_FREQ_B: if (!m_awake) begin
          if (v == 0 && b1[7:6] == 2'h0) m_mult = MULT_DEFAULT;
          else if ((v == 2 || v == 3) && b1[7:6] == 2'h0) m_mult = v;
          else if (v > 3 && v < 7 && b1[7:6] == 2'h1) m_mult = v;
        end
        default: ;
      endcase
    end
  endtask
  task compare;
    chk(pll_mult, m_mult);
    chk(ref_ext, m_ext);
    chk(rst_seen, m_rst);
    chk(sys_clk_en, m_awake);
    chk(pll_on, m_awake);
    chk(osc_on, m_awake);
    chk(freq_reg, m_freq);
    chk(trim_reg, m_trim);
  endtask
  // one command frame; fixed wait covers reset pulse and pll settle
  task send(input logic [7:0] b0, b1, b2, input logic [2:0] n,
    input logic [31:0] d);
    rst_seen = 1'b0;
    if (n != 3'h0) apb(1'b1, REG_DATA, d);
    apb(1'b1, REG_CTRL, {5'h00, n, b2, b1, b0});
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) begin
      // a hung sender is left to the watchdog
      apb(1'b0, REG_STATUS, 32'h0000_0000);
    end
    repeat (ST + 60) @(posedge ref_clk);
    model(b0, b1, b2, d);
    compare();
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(20));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    compare();
    apb(1'b0, 12'h0ff, 32'h0000_0000);
    chk(e, 32'h0000_0001);
    chk(r, 32'h0000_0000);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      op = CMD_FREQ_A + 8'($urandom % 2);
      send(op, fs[i], 8'h00, 3'h0, 32'h0000_0000);
    end
    $display("frequency select test done");
    send(CMD_SEL_EXT, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    send(CMD_SEL_EXT, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    send(CMD_ACTIVE, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    send(CMD_ACTIVE, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    $display("external wake test done");
    send(CMD_FREQ_B, 8'h46, 8'h00, 3'h0, 32'h0000_0000);
    send(CMD_SLEEP, 8'h00, 8'h01, 3'h0, 32'h0000_0000);
    send(8'h80, 8'h10, 8'h00, 3'h4, $urandom);
    send(8'h80, 8'h10, 8'h04, 3'h1, $urandom);
    $display("active test done");
    send(CMD_SLEEP, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    send(CMD_SEL_INT, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    send(CMD_ACTIVE, 8'h00, 8'h00, 3'h0, 32'h0000_0000);
    $display("internal wake test done");
    stop_test();
  end
endmodule
